// ==== pkg/sobm_pkg.sv ====
// Constants, types and helpers for the slave output bit map bridge
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package sobm_pkg;

    // ----------------------------------------------------------------
    // Image layout
    // ----------------------------------------------------------------
    localparam int unsigned WORD_W        = 16;
    localparam int unsigned WORD_COUNT    = 16;
    localparam int unsigned POINT_COUNT   = 256;
    localparam int unsigned POINT_W       = 8;
    localparam int unsigned WORD_IDX_W    = 4;
    localparam int unsigned REMOTE_ADDR_W = 10;
    localparam logic [REMOTE_ADDR_W-1:0] FIRST_WORD_OFS = 10'h004;
    localparam logic [REMOTE_ADDR_W-1:0] LAST_WORD_OFS  = 10'h013;
    localparam logic [WORD_W-1:0]        WORD_RESET     = 16'h0000;

    // ----------------------------------------------------------------
    // Link timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 40;
    localparam int unsigned LINK_BIT_NS     = 1000;
    localparam int unsigned LINK_BIT_CYCLES =
        (LINK_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TICK_W          = 16;
    localparam int unsigned BIT_CNT_W       = 9;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_FIRST = 9'h001;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST  = 9'h100;
    localparam logic [15:0]          FRAME_CNT_ONE = 16'h0001;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SOBM_IDLE,
        SOBM_SYNC,
        SOBM_DATA
    } sobm_state_type;

    typedef struct packed {
        logic                     wr;
        logic                     rd;
        logic [REMOTE_ADDR_W-1:0] addr;
        logic [WORD_W-1:0]        wdata;
    } sobm_host_req_type;

    typedef struct packed {
        logic              valid;
        logic              hit;
        logic [WORD_W-1:0] rdata;
    } sobm_host_rsp_type;

    // ----------------------------------------------------------------
    // Point position helpers
    // ----------------------------------------------------------------
    function automatic logic [WORD_IDX_W-1:0] point_word(input logic [POINT_W-1:0] p);
        point_word = p[POINT_W-1:WORD_IDX_W];
    endfunction

    function automatic logic [WORD_IDX_W-1:0] point_bit(input logic [POINT_W-1:0] p);
        point_bit = p[WORD_IDX_W-1:0];
    endfunction

endpackage

// ==== rtl/sobm_bit_tick.sv ====
// Divider making the one-cycle link bit enable
module sobm_bit_tick #(
    parameter int unsigned CYCLES = sobm_pkg::LINK_BIT_CYCLES
) (
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    output logic      tick_o
);

    localparam logic [sobm_pkg::TICK_W-1:0] TICK_LAST = sobm_pkg::TICK_W'(CYCLES - 1);
    localparam logic [sobm_pkg::TICK_W-1:0] TICK_ONE  = 16'h0001;

    logic [sobm_pkg::TICK_W-1:0] count_reg;
    logic [sobm_pkg::TICK_W-1:0] count_next;
    logic                        wrap;

    assign wrap       = (count_reg == TICK_LAST);
    assign count_next = wrap ? '0 : count_reg + TICK_ONE;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_reg <= '0;
            tick_o    <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_o    <= wrap;
        end
    end

endmodule // sobm_bit_tick

// ==== rtl/sobm_frame_shift.sv ====
// Frame shifter sending the image point 0 first
module sobm_frame_shift #(
    parameter int unsigned POINTS = sobm_pkg::POINT_COUNT
) (
    input  wire logic              core_clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              load_i,
    input  wire logic [POINTS-1:0] load_data_i,
    input  wire logic              shift_i,
    output logic                   bit_o
);

    logic [POINTS-1:0] shift_reg;
    logic [POINTS-1:0] shift_next;

    assign shift_next = load_i  ? load_data_i :
                        shift_i ? {1'b0, shift_reg[POINTS-1:1]} : shift_reg;
    assign bit_o      = shift_reg[0];

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= shift_next;
        end
    end

endmodule // sobm_frame_shift

// ==== rtl/sobm_bridge.sv ====
// Remote output image and its transfer onto the slave link
module sobm_bridge #(
    parameter logic [sobm_pkg::REMOTE_ADDR_W-1:0] BASE_N     = 10'h000,
    parameter int unsigned                        BIT_CYCLES = sobm_pkg::LINK_BIT_CYCLES
) (
    input  wire logic                               core_clk_i,
    input  wire logic                               arst_n_i,
    input  wire sobm_pkg::sobm_host_req_type        host_req_i,
    output sobm_pkg::sobm_host_rsp_type             host_rsp_o,
    output logic [sobm_pkg::POINT_COUNT-1:0]        points_o,
    output logic                                    link_sync_o,
    output logic                                    link_data_o,
    output logic                                    link_strobe_o,
    output logic                                    frame_done_o,
    output logic                                    image_pending_o,
    output logic [15:0]                             frame_count_o
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam int unsigned WW = sobm_pkg::WORD_W;
    localparam int unsigned WC = sobm_pkg::WORD_COUNT;
    localparam int unsigned PC = sobm_pkg::POINT_COUNT;

    logic [WW-1:0]                        image_reg [WC];
    logic [WW-1:0]                        image_next [WC];
    logic [PC-1:0]                        image_flat;
    logic [sobm_pkg::REMOTE_ADDR_W-1:0]   rel_addr;
    logic [sobm_pkg::REMOTE_ADDR_W-1:0]   word_sel_wide;
    logic [sobm_pkg::WORD_IDX_W-1:0]      word_sel;
    logic                                 addr_hit;
    logic                                 wr_hit;
    logic                                 rd_hit;
    logic [WW-1:0]                        rd_word;

    sobm_pkg::sobm_state_type             state_reg;
    sobm_pkg::sobm_state_type             state_next;
    logic [sobm_pkg::BIT_CNT_W-1:0]       bit_cnt_reg;
    logic [sobm_pkg::BIT_CNT_W-1:0]       bit_cnt_next;
    logic                                 tick;
    logic                                 shift_bit;
    logic                                 load_frame;
    logic                                 shift_frame;
    logic                                 frame_end;

    logic                                 sync_reg;
    logic                                 sync_next;
    logic                                 data_reg;
    logic                                 data_next;
    logic                                 strobe_reg;
    logic                                 done_reg;
    logic                                 pending_reg;
    logic                                 pending_next;
    logic [15:0]                          frame_cnt_reg;
    logic [15:0]                          frame_cnt_next;
    logic [PC-1:0]                        points_reg;
    sobm_pkg::sobm_host_rsp_type          rsp_reg;
    sobm_pkg::sobm_host_rsp_type          rsp_next;

    // ----------------------------------------------------------------
    // Remote word decode
    // ----------------------------------------------------------------
    assign rel_addr      = host_req_i.addr - BASE_N;
    assign addr_hit      = (rel_addr >= sobm_pkg::FIRST_WORD_OFS) &&
                           (rel_addr <= sobm_pkg::LAST_WORD_OFS);
    assign word_sel_wide = rel_addr - sobm_pkg::FIRST_WORD_OFS;
    assign word_sel      = word_sel_wide[sobm_pkg::WORD_IDX_W-1:0];
    assign wr_hit        = host_req_i.wr && addr_hit;
    assign rd_hit        = host_req_i.rd && addr_hit;
    assign rd_word       = image_reg[word_sel];

    // ----------------------------------------------------------------
    // Image storage
    // ----------------------------------------------------------------
    always_comb begin
        for (int w = 0; w < WC; w++) begin
            image_next[w] = image_reg[w];
        end
        if (wr_hit) begin
            image_next[word_sel] = host_req_i.wdata;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int w = 0; w < WC; w++) begin
                image_reg[w] <= sobm_pkg::WORD_RESET;
            end
        end else begin
            image_reg <= image_next;
        end
    end

    // Point p lands at word p/16, bit p mod 16
    always_comb begin
        image_flat = '0;
        for (int p = 0; p < PC; p++) begin
            image_flat[p] =
                image_reg[sobm_pkg::point_word(8'(p))][sobm_pkg::point_bit(8'(p))];
        end
    end

    // ----------------------------------------------------------------
    // Host read answer
    // ----------------------------------------------------------------
    assign rsp_next.valid = host_req_i.rd;
    assign rsp_next.hit   = rd_hit;
    assign rsp_next.rdata = rd_hit ? rd_word : '0;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    // ----------------------------------------------------------------
    // Link bit timing and shifter
    // ----------------------------------------------------------------
    sobm_bit_tick #(
        .CYCLES (BIT_CYCLES)
    ) u_tick (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .tick_o     (tick)
    );

    sobm_frame_shift #(
        .POINTS (PC)
    ) u_shift (
        .core_clk_i  (core_clk_i),
        .arst_n_i    (arst_n_i),
        .load_i      (load_frame),
        .load_data_i (image_flat),
        .shift_i     (shift_frame),
        .bit_o       (shift_bit)
    );

    // ----------------------------------------------------------------
    // Frame sequencer
    // ----------------------------------------------------------------
    assign frame_end   = (bit_cnt_reg == sobm_pkg::BIT_CNT_LAST);
    assign load_frame  = tick && ((state_reg == sobm_pkg::SOBM_IDLE) ||
                                  ((state_reg == sobm_pkg::SOBM_DATA) && frame_end));
    assign shift_frame = tick && ((state_reg == sobm_pkg::SOBM_SYNC) ||
                                  ((state_reg == sobm_pkg::SOBM_DATA) && !frame_end));

    // Frames repeat without host action, broadcast with no identifier filter
    always_comb begin
        state_next   = state_reg;
        bit_cnt_next = bit_cnt_reg;
        sync_next    = sync_reg;
        data_next    = data_reg;
        if (tick) begin
            case (state_reg)
                sobm_pkg::SOBM_IDLE: begin
                    state_next = sobm_pkg::SOBM_SYNC;
                    sync_next  = 1'b1;
                    data_next  = 1'b0;
                end
                sobm_pkg::SOBM_SYNC: begin
                    state_next   = sobm_pkg::SOBM_DATA;
                    sync_next    = 1'b0;
                    data_next    = shift_bit;
                    bit_cnt_next = sobm_pkg::BIT_CNT_FIRST;
                end
                sobm_pkg::SOBM_DATA: begin
                    if (frame_end) begin
                        state_next = sobm_pkg::SOBM_SYNC;
                        sync_next  = 1'b1;
                        data_next  = 1'b0;
                    end else begin
                        data_next    = shift_bit;
                        bit_cnt_next = bit_cnt_reg + sobm_pkg::BIT_CNT_FIRST;
                    end
                end
                default: begin
                    state_next = sobm_pkg::SOBM_IDLE;
                    sync_next  = 1'b0;
                    data_next  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg   <= sobm_pkg::SOBM_IDLE;
            bit_cnt_reg <= '0;
            sync_reg    <= 1'b0;
            data_reg    <= 1'b0;
            strobe_reg  <= 1'b0;
        end else begin
            state_reg   <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            sync_reg    <= sync_next;
            data_reg    <= data_next;
            strobe_reg  <= tick;
        end
    end

    // ----------------------------------------------------------------
    // Status: frame count, pending image, applied points
    // ----------------------------------------------------------------
    assign frame_cnt_next = (load_frame && (state_reg == sobm_pkg::SOBM_DATA)) ?
                            frame_cnt_reg + sobm_pkg::FRAME_CNT_ONE : frame_cnt_reg;
    // A write in the loading cycle wins over the clear
    assign pending_next   = wr_hit ? 1'b1 : (load_frame ? 1'b0 : pending_reg);

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            frame_cnt_reg <= '0;
            pending_reg   <= 1'b0;
            done_reg      <= 1'b0;
            points_reg    <= '0;
        end else begin
            frame_cnt_reg <= frame_cnt_next;
            pending_reg   <= pending_next;
            done_reg      <= load_frame && (state_reg == sobm_pkg::SOBM_DATA);
            points_reg    <= image_flat;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign host_rsp_o      = rsp_reg;
    assign points_o        = points_reg;
    assign link_sync_o     = sync_reg;
    assign link_data_o     = data_reg;
    assign link_strobe_o   = strobe_reg;
    assign frame_done_o    = done_reg;
    assign image_pending_o = pending_reg;
    assign frame_count_o   = frame_cnt_reg;

endmodule // sobm_bridge

// ==== testbench/sobm_bridge_asserts.sv ====
// Port checker for the slave output bit map bridge
module sobm_bridge_asserts #(
    parameter logic [9:0]  BASE_N     = 10'h000,
    parameter int unsigned BIT_CYCLES = 3
) (
    input wire logic                        core_clk_i,
    input wire logic                        arst_n_i,
    input wire sobm_pkg::sobm_host_req_type host_req_i,
    input wire sobm_pkg::sobm_host_rsp_type host_rsp_o,
    input wire logic [255:0]                points_o,
    input wire logic                        link_sync_o,
    input wire logic                        link_data_o,
    input wire logic                        link_strobe_o,
    input wire logic                        frame_done_o,
    input wire logic                        image_pending_o,
    input wire logic [15:0]                 frame_count_o
);
    wire logic [9:0] ofs = host_req_i.addr - BASE_N;
    wire logic inwin = (ofs >= 10'h004) && (ofs <= 10'h013);
    wire logic [3:0] widx = ofs[3:0] - 4'h4;
    logic [7:0] gap_reg;
    logic       seen_reg;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gap_reg <= 8'h00;
            seen_reg <= 1'b0;
        end else begin
            gap_reg <= link_strobe_o ? 8'h00 : gap_reg + 8'h01;
            seen_reg <= seen_reg | link_strobe_o;
        end
    end
    // ----------
    // Assertions
    // ----------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_wr_win;
        host_req_i.wr && inwin;
    endsequence
    sequence s_no_rewrite;
        !(host_req_i.wr && (host_req_i.addr == $past(host_req_i.addr)));
    endsequence
    a_write_lands: assert property (s_wr_win ##1 s_no_rewrite |=>
        points_o[{$past(widx, 2), 4'h0} +: 16] == $past(host_req_i.wdata, 2))
        else $error("written word not on points");
    a_points_hold: assert property (!(host_req_i.wr && inwin) |-> ##2 $stable(points_o))
        else $error("points changed without write");
    a_read_answer: assert property (host_req_i.rd |=> host_rsp_o.valid
        && (host_rsp_o.hit == $past(inwin)) && (host_rsp_o.rdata ==
        ($past(inwin) ? points_o[{$past(widx), 4'h0} +: 16] : 16'h0000)))
        else $error("read answer wrong");
    a_no_spur_rsp: assert property (!host_req_i.rd |=> !host_rsp_o.valid)
        else $error("answer without read");
    a_strobe_period: assert property (link_strobe_o && seen_reg |->
        gap_reg == 8'(BIT_CYCLES - 1))
        else $error("bit period length wrong");
    a_sync_no_data: assert property (link_sync_o |-> !link_data_o)
        else $error("data during sync");
    a_bit_stands: assert property (!link_strobe_o |-> $stable({link_sync_o, link_data_o}))
        else $error("link changed mid period");
    a_done_at_sync: assert property (frame_done_o |-> link_sync_o && link_strobe_o)
        else $error("frame end off sync");
    a_count_step: assert property (frame_count_o ==
        $past(frame_count_o) + {15'h0000, frame_done_o})
        else $error("frame count step wrong");
    a_pending_set: assert property (host_req_i.wr && inwin |=> image_pending_o)
        else $error("pending not set by write");
    a_pending_clear: assert property (frame_done_o && !$past(host_req_i.wr && inwin)
        |-> !image_pending_o)
        else $error("pending not cleared at frame load");
endmodule // sobm_bridge_asserts

bind sobm_bridge sobm_bridge_asserts #(.BASE_N(BASE_N), .BIT_CYCLES(BIT_CYCLES)) u_chk (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .host_req_i(host_req_i),
    .host_rsp_o(host_rsp_o), .points_o(points_o), .link_sync_o(link_sync_o),
    .link_data_o(link_data_o), .link_strobe_o(link_strobe_o), .frame_done_o(frame_done_o),
    .image_pending_o(image_pending_o), .frame_count_o(frame_count_o));

// ==== testbench/sobm_slave_model.sv ====
// Behavioural slave module taking its points off the link
module sobm_slave_model #(
    parameter int unsigned ADDR = 0,
    parameter int unsigned NPTS = 1
) (
    input wire logic        core_clk_i,
    input wire logic        arst_n_i,
    input wire logic        link_sync_i,
    input wire logic        link_data_i,
    input wire logic        link_strobe_i,
    output logic [NPTS-1:0] outs_o,
    output logic            upd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0]      idx_reg;
    logic [NPTS-1:0] shadow_reg;
    // No identifier check, every connected slave listens
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            idx_reg <= 9'h000;
            shadow_reg <= '0;
            outs_o <= '0;
            upd_o <= 1'b0;
        end else begin
            upd_o <= link_strobe_i && link_sync_i && (idx_reg == 9'h100);
            if (link_strobe_i && link_sync_i) begin
                idx_reg <= 9'h000;
                if (idx_reg == 9'h100) outs_o <= shadow_reg;
            end else if (link_strobe_i) begin
                idx_reg <= idx_reg + 9'h001;
                if ((idx_reg >= ADDR) && (idx_reg < ADDR + NPTS)) begin
                    shadow_reg[idx_reg - ADDR] <= link_data_i;
                end
            end
        end
    end
endmodule // sobm_slave_model

// ==== testbench/slave_output_bit_map_test.sv ====
// Self-checking bench for the slave output bit map bridge
module slave_output_bit_map_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [9:0] BASE = 10'h020;
    logic core_clk_i, arst_n_i, link_sync_o, link_data_o, link_strobe_o, frame_done_o;
    logic image_pending_o, s16, s200, u30, u16, u200;
    logic [1:0]   s30;
    logic [15:0]  frame_count_o;
    logic [255:0] points_o, exp_img;
    logic [16:0]  exp_q[$];
    sobm_pkg::sobm_host_req_type host_req_i;
    sobm_pkg::sobm_host_rsp_type host_rsp_o;
    int error_cnt, tests_run, upd_n;

    sobm_bridge #(.BASE_N(BASE), .BIT_CYCLES(3)) DUT (.core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i), .host_req_i(host_req_i), .host_rsp_o(host_rsp_o),
        .points_o(points_o), .link_sync_o(link_sync_o), .link_data_o(link_data_o),
        .link_strobe_o(link_strobe_o), .frame_done_o(frame_done_o),
        .image_pending_o(image_pending_o), .frame_count_o(frame_count_o));
    sobm_slave_model #(.ADDR(30), .NPTS(2)) u_s30 (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .link_sync_i(link_sync_o), .link_data_i(link_data_o), .link_strobe_i(link_strobe_o),
        .outs_o(s30), .upd_o(u30));
    sobm_slave_model #(.ADDR(16)) u_s16 (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .link_sync_i(link_sync_o), .link_data_i(link_data_o), .link_strobe_i(link_strobe_o),
        .outs_o(s16), .upd_o(u16));
    sobm_slave_model #(.ADDR(200)) u_s200 (.core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i), .link_sync_i(link_sync_o), .link_data_i(link_data_o),
        .link_strobe_i(link_strobe_o), .outs_o(s200), .upd_o(u200));

    task automatic tally_and_finish;
        if (exp_q.size() != 0) begin
            error_cnt++;
            $display("BAD rsp_left exp %0d got %0d", 0, exp_q.size());
        end
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp_word(input string what, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (e !== s) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", what, e, s);
        end
    endtask
    task automatic cmp_rsp(input logic [16:0] e, input logic [16:0] s);
        tests_run++;
        if (e !== s) begin
            error_cnt++;
            $display("BAD rsp exp %h got %h", e, s);
        end
    endtask
    // Host access; reads note their answer, writes that hit the window update the image
    task automatic acc(input logic w, input logic r, input logic [9:0] a, input logic [15:0] d);
        logic hit;
        int   k;
        hit = (a >= BASE + 10'h004) && (a <= BASE + 10'h013);
        k = int'(a - BASE - 10'h004) * 16;
        @(negedge core_clk_i);
        host_req_i <= {w, r, a, d};
        if (r) exp_q.push_back({hit, hit ? exp_img[k +: 16] : 16'h0000});
        if (w && hit) exp_img[k +: 16] = d;
        @(negedge core_clk_i);
        host_req_i <= '0;
    endtask
    task automatic wait_frames(input int n);
        int t;
        t = upd_n + n;
        for (int c = 0; upd_n < t; c++) begin
            if (c > 3000) begin
                error_cnt++;
                tally_and_finish();
            end
            @(negedge core_clk_i);
        end
    endtask
    task automatic check_out;
        for (int k = 0; k < 16; k++) begin
            cmp_word("points", exp_img[k*16 +: 16], points_o[k*16 +: 16]);
        end
        cmp_word("s30", {14'h0000, exp_img[31:30]}, {14'h0000, s30});
        cmp_word("s16", {15'h0000, exp_img[16]}, {15'h0000, s16});
        cmp_word("s200", {15'h0000, exp_img[200]}, {15'h0000, s200});
    endtask

    always @(negedge core_clk_i) begin
        if (u30 === 1'b1) begin
            upd_n++;
            cmp_word("upd", 16'h0003, {14'h0000, u16, u200});
        end
        if (host_rsp_o.valid === 1'b1) begin
            cmp_rsp(exp_q.size() > 0 ? exp_q.pop_front() : 17'h1ffff, host_rsp_o[16:0]);
        end
    end
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (100000) @(negedge core_clk_i);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        arst_n_i = 1'b0;
        host_req_i = '0;
        exp_img = '0;
        error_cnt = 0;
        tests_run = 0;
        upd_n = 0;
        void'($urandom(28617));
        repeat (20) @(negedge core_clk_i);
        arst_n_i = 1'b1;
        for (int k = 3; k <= 20; k++) acc(1'b0, 1'b1, BASE + 10'(k), 16'h0000);
        for (int k = 4; k <= 19; k++) acc(1'b1, 1'b0, BASE + 10'(k), 16'($urandom));
        acc(1'b1, 1'b0, BASE + 10'h003, 16'($urandom));
        acc(1'b1, 1'b0, BASE + 10'h014, 16'($urandom));
        for (int k = 3; k <= 20; k++) acc(1'b0, 1'b1, BASE + 10'(k), 16'h0000);
        acc(1'b1, 1'b0, BASE + 10'h005, 16'hc001);
        wait_frames(2);
        check_out();
        acc(1'b1, 1'b0, BASE + 10'h005, 16'h4000);
        acc(1'b1, 1'b0, BASE + 10'h010, ~exp_img[207:192]);
        wait_frames(2);
        check_out();
        arst_n_i = 1'b0;
        exp_img = '0;
        repeat (3) @(negedge core_clk_i);
        arst_n_i = 1'b1;
        acc(1'b0, 1'b1, BASE + 10'h005, 16'h0000);
        wait_frames(2);
        check_out();
        tally_and_finish();
    end
endmodule // slave_output_bit_map_test
